// *** include/tmr_defs.svh ***
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// ----------------------------------------------------------------------------
// Register word indices (byte address is index times four)
// ----------------------------------------------------------------------------
`define TMR_IDX_CTRL 3'h0
`define TMR_IDX_CNT 3'h1
`define TMR_IDX_CMP 3'h2
`define TMR_IDX_FLAG 3'h3
`define TMR_IDX_PDIR 3'h4

// ----------------------------------------------------------------------------
// Control and flag register field positions
// ----------------------------------------------------------------------------
`define TMR_FORCE_BIT 7
`define TMR_WGM_LO_BIT 6
`define TMR_COM_HI_BIT 5
`define TMR_COM_LO_BIT 4
`define TMR_WGM_HI_BIT 3
`define TMR_CS_HI_BIT 2
`define TMR_CS_LO_BIT 0
`define TMR_FLAG_OVF_BIT 0
`define TMR_FLAG_CMP_BIT 1

// ----------------------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------------------
`define TMR_CTRL_RST 8'h00
`define TMR_CNT_MAX 8'hFF
`define TMR_CNT_BOTTOM 8'h00

// ----------------------------------------------------------------------------
// Prescaler tap masks for divide by 8, 64, 256 and 1024
// ----------------------------------------------------------------------------
`define TMR_DIV8_MASK 10'h007
`define TMR_DIV64_MASK 10'h03F
`define TMR_DIV256_MASK 10'h0FF
`define TMR_DIV1024_MASK 10'h3FF

`endif

// *** include/tmr_pkg.sv ***
package tmr_pkg;

  // --------------------------------------------------------------------------
  // Waveform modes and clock sources
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    TMR_NORMAL = 2'b00,
    TMR_PHASE = 2'b01,
    TMR_CTC = 2'b10,
    TMR_FAST = 2'b11
  } tmr_wave_e;

  typedef enum logic [2:0] {
    TMR_CS_STOP = 3'b000,
    TMR_CS_DIV1 = 3'b001,
    TMR_CS_DIV8 = 3'b010,
    TMR_CS_DIV64 = 3'b011,
    TMR_CS_DIV256 = 3'b100,
    TMR_CS_DIV1024 = 3'b101,
    TMR_CS_EXT_FALL = 3'b110,
    TMR_CS_EXT_RISE = 3'b111
  } tmr_clksel_e;

  // --------------------------------------------------------------------------
  // State of the pin synchroniser
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;
  } tmr_sync_s;

  // --------------------------------------------------------------------------
  // State of the timer core and its bus slave
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl_r;
    logic [7:0] cnt_r;
    logic [7:0] cmp_act_r;
    logic [7:0] cmp_buf_r;
    logic down_r;
    logic up_seen_r;
    logic block_r;
    logic oc_r;
    logic oe_r;
    logic pin_dir_r;
    logic ovf_r;
    logic cmpf_r;
    logic [9:0] pre_r;
    logic ext_prev_r;
    logic aph_r;
    logic aph_wr_r;
    logic aph_hit_r;
    logic [2:0] aph_idx_r;
    logic [31:0] rdata_r;
    logic ready_r;
    logic resp_r;
  } tmr_state_s;

endpackage : tmr_pkg

// *** core/tmr_sync.sv ***
module tmr_sync
  import tmr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  output logic level
);

  // ---------------------------------------------------------------------------
  // Three stage sampler with agreement filter
  // ---------------------------------------------------------------------------
  tmr_sync_s q;
  tmr_sync_s n;

  // Level only moves once the second and third stages agree
  always_comb begin
    n = q;
    n.s1_r = pin;
    n.s2_r = q.s1_r;
    n.s3_r = q.s2_r;
    if (q.s2_r == q.s3_r) begin
      n.level_r = q.s3_r;
    end
  end

  // Register the whole state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign level = q.level_r;

endmodule : tmr_sync

// *** core/tmr_top.sv ***
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`include "tmr_defs.svh"

module tmr_top
  import tmr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic external_count_pin,
  input wire logic [1:0] flag_ack,
  output logic compare_output,
  output logic compare_output_oe,
  output logic overflow_flag,
  output logic compare_flag
);

  // ---------------------------------------------------------------------------
  // State and decoded helpers
  // ---------------------------------------------------------------------------
  tmr_state_s q;
  tmr_state_s n;
  logic ext_level;
  tmr_wave_e wmode;
  tmr_clksel_e csel;
  logic [1:0] com;
  logic tick;
  logic match;
  logic cmp_max;
  logic ovf_set;
  logic do_set;
  logic do_clr;
  logic do_tog;
  logic bus_wr;
  logic ctrl_wr;
  logic cnt_wr;
  logic cmp_wr;
  logic flag_wr;
  logic force_hit;
  logic [1:0] clr_req;

  // Pin edges count regardless of the pin's port direction
  tmr_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(external_count_pin),
    .level(ext_level)
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    n = q;
    wmode = tmr_wave_e'({q.ctrl_r[`TMR_WGM_HI_BIT], q.ctrl_r[`TMR_WGM_LO_BIT]});
    csel = tmr_clksel_e'(q.ctrl_r[`TMR_CS_HI_BIT:`TMR_CS_LO_BIT]);
    com = q.ctrl_r[`TMR_COM_HI_BIT:`TMR_COM_LO_BIT];
    ovf_set = 1'b0;
    do_set = 1'b0;
    do_clr = 1'b0;
    do_tog = 1'b0;
    bus_wr = q.aph_r && q.aph_wr_r && q.aph_hit_r;
    ctrl_wr = bus_wr && (q.aph_idx_r == `TMR_IDX_CTRL);
    cnt_wr = bus_wr && (q.aph_idx_r == `TMR_IDX_CNT);
    cmp_wr = bus_wr && (q.aph_idx_r == `TMR_IDX_CMP);
    flag_wr = bus_wr && (q.aph_idx_r == `TMR_IDX_FLAG);
    force_hit = ctrl_wr && hwdata[`TMR_FORCE_BIT] && !hwdata[`TMR_WGM_LO_BIT];
    clr_req = flag_ack | (flag_wr ? hwdata[1:0] : 2'b00);

    // Free running prescaler; the tick is an enable, never a clock
    n.pre_r = q.pre_r + 10'h001;
    n.ext_prev_r = ext_level;
    unique case (csel)
      TMR_CS_STOP: tick = 1'b0;
      TMR_CS_DIV1: tick = 1'b1;
      TMR_CS_DIV8: tick = (q.pre_r & `TMR_DIV8_MASK) == `TMR_DIV8_MASK;
      TMR_CS_DIV64: tick = (q.pre_r & `TMR_DIV64_MASK) == `TMR_DIV64_MASK;
      TMR_CS_DIV256: tick = (q.pre_r & `TMR_DIV256_MASK) == `TMR_DIV256_MASK;
      TMR_CS_DIV1024: tick = q.pre_r == `TMR_DIV1024_MASK;
      TMR_CS_EXT_FALL: tick = q.ext_prev_r && !ext_level;
      TMR_CS_EXT_RISE: tick = !q.ext_prev_r && ext_level;
    endcase

    // A counter write blanks the match of the following tick
    match = tick && (q.cnt_r == q.cmp_act_r) && !q.block_r;
    cmp_max = q.cmp_act_r == `TMR_CNT_MAX;
    if (tick) begin
      n.block_r = 1'b0;
    end

    // Counting sequence per waveform mode
    if (tick) begin
      unique case (wmode)
        TMR_NORMAL: begin
          n.cnt_r = q.cnt_r + 8'h01;
          ovf_set = q.cnt_r == `TMR_CNT_MAX;
        end
        TMR_CTC: begin
          n.cnt_r = match ? `TMR_CNT_BOTTOM : q.cnt_r + 8'h01;
          ovf_set = q.cnt_r == `TMR_CNT_MAX;
        end
        TMR_FAST: begin
          n.cnt_r = q.cnt_r + 8'h01;
          ovf_set = q.cnt_r == `TMR_CNT_MAX;
          if (q.cnt_r == `TMR_CNT_MAX) begin
            n.cmp_act_r = q.cmp_buf_r;
          end
        end
        TMR_PHASE: begin
          // Up to max, turn at once, down to zero: 510 ticks a period
          if (!q.down_r) begin
            if (q.cnt_r == `TMR_CNT_MAX) begin
              n.down_r = 1'b1;
              n.cnt_r = q.cnt_r - 8'h01;
              n.cmp_act_r = q.cmp_buf_r;
            end else begin
              n.cnt_r = q.cnt_r + 8'h01;
            end
          end else if (q.cnt_r <= 8'h01) begin
            n.down_r = 1'b0;
            n.cnt_r = (q.cnt_r == 8'h00) ? 8'h01 : 8'h00;
            ovf_set = q.cnt_r == 8'h01;
          end else begin
            n.cnt_r = q.cnt_r - 8'h01;
          end
        end
      endcase
    end

    // Output actions per waveform mode
    unique case (wmode)
      TMR_NORMAL, TMR_CTC: begin
        if (match) begin
          do_tog = com == 2'b01;
          do_clr = com == 2'b10;
          do_set = com == 2'b11;
        end
      end
      TMR_FAST: begin
        if (com[1]) begin
          if (match && !cmp_max) begin
            do_set = com[0];
            do_clr = !com[0];
          end else if (tick && q.cnt_r == `TMR_CNT_MAX) begin
            do_set = !com[0];
            do_clr = com[0];
          end
        end
      end
      TMR_PHASE: begin
        if (com[1]) begin
          if (tick && !q.down_r && q.cnt_r == `TMR_CNT_BOTTOM && !q.up_seen_r && !cmp_max) begin
            // No up match in the last slope: take its level at zero
            do_set = com[0];
            do_clr = !com[0];
          end
          if (match && !cmp_max) begin
            do_set = q.down_r ? !com[0] : com[0];
            do_clr = q.down_r ? com[0] : !com[0];
          end else if (tick && cmp_max && q.cnt_r == `TMR_CNT_MAX) begin
            do_set = !com[0];
            do_clr = com[0];
          end
        end
        if (tick && !q.down_r && q.cnt_r == `TMR_CNT_BOTTOM) begin
          n.up_seen_r = match;
        end else if (match && !q.down_r && !cmp_max) begin // Top match at max is ignored
          n.up_seen_r = 1'b1;
        end
      end
    endcase

    // Force strobe overrides the tick action with the freshly written field
    if (force_hit) begin
      do_tog = hwdata[5:4] == 2'b01;
      do_clr = hwdata[5:4] == 2'b10;
      do_set = hwdata[5:4] == 2'b11;
    end
    if (do_set) begin
      n.oc_r = 1'b1;
    end else if (do_clr) begin
      n.oc_r = 1'b0;
    end else if (do_tog) begin
      n.oc_r = !q.oc_r;
    end

    // Register writes in the data phase
    if (ctrl_wr) begin
      n.ctrl_r = {1'b0, hwdata[6:0]};
    end
    if (cnt_wr) begin
      n.cnt_r = hwdata[7:0];
      n.block_r = 1'b1;
      n.up_seen_r = 1'b0;
    end
    if (cmp_wr) begin
      n.cmp_buf_r = hwdata[7:0];
      if (!q.ctrl_r[`TMR_WGM_LO_BIT]) begin
        n.cmp_act_r = hwdata[7:0];
      end
    end
    if (bus_wr && q.aph_idx_r == `TMR_IDX_PDIR) begin
      n.pin_dir_r = hwdata[0];
    end

    // Flags: a set in the same cycle beats any clear
    n.ovf_r = ovf_set || (q.ovf_r && !clr_req[`TMR_FLAG_OVF_BIT]);
    n.cmpf_r = match || (q.cmpf_r && !clr_req[`TMR_FLAG_CMP_BIT]);
    n.oe_r = (n.ctrl_r[5:4] != 2'b00) && n.pin_dir_r;

    // Address phase capture and read data for the coming data phase
    n.ready_r = 1'b1;
    n.resp_r = 1'b0;
    n.rdata_r = 32'h0000_0000;
    n.aph_r = hsel && htrans[1] && hready;
    n.aph_wr_r = hwrite;
    n.aph_idx_r = haddr[4:2];
    n.aph_hit_r = (haddr[31:5] == 27'h0) && (haddr[4:2] <= `TMR_IDX_PDIR);
    if (n.aph_r && !hwrite) begin
      unique case (haddr[4:2])
        `TMR_IDX_CTRL: n.rdata_r = {24'h00_0000, 1'b0, q.ctrl_r[6:0]};
        `TMR_IDX_CNT: n.rdata_r = {24'h00_0000, q.cnt_r};
        `TMR_IDX_CMP: n.rdata_r = {24'h00_0000, q.cmp_buf_r};
        `TMR_IDX_FLAG: n.rdata_r = {30'h0, q.cmpf_r, q.ovf_r};
        `TMR_IDX_PDIR: n.rdata_r = {31'h0, q.pin_dir_r};
        default: n.rdata_r = 32'h0000_0000;
      endcase
      if (!n.aph_hit_r) begin
        n.rdata_r = 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.ctrl_r <= `TMR_CTRL_RST;
      q.up_seen_r <= 1'b1;
      q.ready_r <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from the state register
  assign hrdata = q.rdata_r;
  assign hreadyout = q.ready_r;
  assign hresp = q.resp_r;
  assign compare_output = q.oc_r;
  assign compare_output_oe = q.oe_r;
  assign overflow_flag = q.ovf_r;
  assign compare_flag = q.cmpf_r;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  phase_top_turn_a: assert property (
    tick && wmode == TMR_PHASE && !q.down_r && q.cnt_r == 8'hFF && !cnt_wr && !ctrl_wr
    |=> q.cnt_r == 8'hFE && q.down_r)
    else $error("dual slope did not turn at max");

  phase_bottom_ovf_a: assert property (
    tick && wmode == TMR_PHASE && q.down_r && q.cnt_r == 8'h01 && !cnt_wr
    |=> q.cnt_r == 8'h00 && q.ovf_r && !q.down_r)
    else $error("dual slope overflow missing at zero");

  single_wrap_a: assert property (
    tick && wmode != TMR_PHASE && q.cnt_r == 8'hFF && !cnt_wr
    |=> q.cnt_r == 8'h00 && q.ovf_r)
    else $error("single slope wrap or overflow wrong");

  ctrl_read_zero_a: assert property (
    q.aph_r && !q.aph_wr_r && q.aph_idx_r == `TMR_IDX_CTRL |-> q.rdata_r[7] == 1'b0)
    else $error("force strobe read back as one");

  stopped_hold_a: assert property (
    csel == TMR_CS_STOP && !cnt_wr |=> $stable(q.cnt_r) && !$rose(q.ovf_r) && !$rose(q.cmpf_r))
    else $error("stopped timer moved or flagged");

  force_quiet_a: assert property (
    force_hit && !tick |=> !$rose(q.cmpf_r) && $stable(q.cnt_r))
    else $error("forced compare touched flag or counter");

  force_set_a: assert property (
    force_hit && hwdata[5:4] == 2'b11 |=> q.oc_r)
    else $error("forced set not applied");

  fast_bottom_set_a: assert property (
    tick && wmode == TMR_FAST && com == 2'b10 && q.cnt_r == 8'hFF && !ctrl_wr
    |=> q.oc_r ##1 (q.cnt_r == 8'h00 || $past(tick) == 1'b0 || q.cnt_r == 8'h01))
    else $error("fast mode output not set at zero");

  phase_up_clear_a: assert property (
    match && wmode == TMR_PHASE && com == 2'b10 && !q.down_r && !cmp_max && !ctrl_wr
    |=> !q.oc_r)
    else $error("up match did not clear output");

  div8_tap_a: assert property (
    csel == TMR_CS_DIV8 && tick |-> q.pre_r[2:0] == 3'h7)
    else $error("divide by 8 tick off its tap");

  write_blank_a: assert property (
    cnt_wr ##1 (tick && !flag_wr && flag_ack == 2'b00) |=> !$rose(q.cmpf_r))
    else $error("match not blanked after counter write");

  set_wins_a: assert property (
    ovf_set && clr_req[0] |=> q.ovf_r)
    else $error("overflow lost against clear");

  pin_enable_a: assert property (
    q.oe_r |-> q.pin_dir_r && q.ctrl_r[5:4] != 2'b00)
    else $error("pin driver enabled without owner");

endmodule : tmr_top

// *** testbench/tmr_load.sv ***
// ----------------------------------------------------------------------------
// Load on the compare output pin: a pulled-down wire and a period meter
// ----------------------------------------------------------------------------
module tmr_load (
  input wire logic hclk,
  input wire logic pin_drive,
  input wire logic pin_oe,
  output logic level,
  output logic [31:0] period,
  output logic [31:0] high_time,
  output logic [31:0] rises
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev = 1'b0;
  logic [31:0] cnt = 32'h0000_0000;
  logic [31:0] hcnt = 32'h0000_0000;

  // Pin floats to the pull-down unless the driver is enabled
  assign level = pin_oe ? pin_drive : 1'b0;

  // Cycles between rising edges and high cycles within that span
  initial begin
    period = 32'h0000_0000;
    high_time = 32'h0000_0000;
    rises = 32'h0000_0000;
  end
  always @(posedge hclk) begin
    prev <= level;
    if (level && !prev) begin
      period <= cnt;
      high_time <= hcnt;
      rises <= rises + 1;
      cnt <= 32'h0000_0001;
      hcnt <= 32'h0000_0001;
    end else begin
      cnt <= cnt + 1;
      hcnt <= hcnt + {31'h0, level};
    end
  end
endmodule : tmr_load

// *** testbench/timer8_waveform_mode_control_bench.sv ***
`include "tmr_defs.svh"

module timer8_waveform_mode_control_bench
  import tmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [2:0] idx;
    logic [31:0] wd;
    logic [31:0] exp;
  } tmr_row_s;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic pin = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [1:0] ack = 2'b00;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, rd, per, hi, rises, r0;
  logic hreadyout, hresp, co, coe, ovf, cmpf, lvl;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;
  int div [4] = '{8, 64, 256, 1024};
  // Written value beside its expected readback; index 5 is unmapped
  tmr_row_s rows [5] = '{
    '{`TMR_IDX_CTRL, 32'h0000_00B0, 32'h0000_0030},
    '{`TMR_IDX_CMP, 32'h0000_005A, 32'h0000_005A},
    '{`TMR_IDX_CNT, 32'h0000_0033, 32'h0000_0033},
    '{`TMR_IDX_PDIR, 32'h0000_0001, 32'h0000_0001},
    '{3'h5, 32'h0000_00FF, 32'h0000_0000}
  };

  always #5 hclk = ~hclk;

  tmr_top u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .external_count_pin(pin), .flag_ack(ack), .compare_output(co),
    .compare_output_oe(coe), .overflow_flag(ovf), .compare_flag(cmpf)
  );

  tmr_load u_load (
    .hclk(hclk), .pin_drive(co), .pin_oe(coe), .level(lvl),
    .period(per), .high_time(hi), .rises(rises)
  );

  // --------------------------------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  // Address phase held until hready, then data phase until hready again
  task automatic bus(input logic wr, input logic [2:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {27'h0, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  task automatic results;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // Hang guard, well above the expected run of about 23500 cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      results();
    end
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    cyc(2);
    hresetn <= 1'b1;
    bus(1'b0, `TMR_IDX_CTRL, 32'h0);
    chk_word(rd, 32'h0000_0000);
    chk_bit(hresp, 1'b0);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].idx, rows[i].wd);
      bus(1'b0, rows[i].idx, 32'h0);
      chk_word(rd, rows[i].exp);
    end
    // Forced set survived; no flag, driver on
    chk_bit(co, 1'b1);
    chk_bit(cmpf, 1'b0);
    chk_bit(coe, 1'b1);
    bus(1'b1, `TMR_IDX_CTRL, 32'h0000_00A0);
    cyc(1);
    chk_bit(co, 1'b0);
    // Forced toggle in clear-on-match mode must leave the counter alone
    bus(1'b1, `TMR_IDX_CTRL, 32'h0000_0098);
    cyc(1);
    chk_bit(co, 1'b1);
    bus(1'b0, `TMR_IDX_CNT, 32'h0);
    chk_word(rd, 32'h0000_0033);
    chk_bit(cmpf, 1'b0);
    // Normal mode wrap sets overflow; write one clears it
    bus(1'b1, `TMR_IDX_CTRL, 32'h0000_0000);
    bus(1'b1, `TMR_IDX_CNT, 32'h0000_00FE);
    bus(1'b1, `TMR_IDX_CTRL, 32'h0000_0001);
    cyc(4);
    bus(1'b1, `TMR_IDX_CTRL, 32'h0000_0000);
    chk_bit(ovf, 1'b1);
    bus(1'b1, `TMR_IDX_FLAG, 32'h0000_0001);
    cyc(1);
    chk_bit(ovf, 1'b0);
    // Counter written to the compare value while running: next tick's match is blanked
    bus(1'b1, `TMR_IDX_CTRL, 32'h0000_0001);
    bus(1'b1, `TMR_IDX_CNT, 32'h0000_005A);
    cyc(6);
    bus(1'b1, `TMR_IDX_CTRL, 32'h0000_0000);
    chk_bit(cmpf, 1'b0);
    bus(1'b1, `TMR_IDX_CNT, 32'h0000_0050);
    bus(1'b1, `TMR_IDX_CTRL, 32'h0000_0001);
    cyc(20);
    bus(1'b1, `TMR_IDX_CTRL, 32'h0000_0000);
    chk_bit(cmpf, 1'b1);
    ack <= 2'b10;
    cyc(1);
    ack <= 2'b00;
    cyc(1);
    chk_bit(cmpf, 1'b0);
    // Prescaler taps: about four ticks in a window of four divided periods
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `TMR_IDX_CNT, 32'h0);
      bus(1'b1, `TMR_IDX_CTRL, 32'(2 + i));
      cyc(4 * div[i] - 2);
      bus(1'b1, `TMR_IDX_CTRL, 32'h0);
      bus(1'b0, `TMR_IDX_CNT, 32'h0);
      chk_bit(rd inside {32'd3, 32'd4, 32'd5}, 1'b1);
    end
    // Five pin pulses count once per chosen edge, falling then rising
    for (int cs = 6; cs < 8; cs++) begin
      bus(1'b1, `TMR_IDX_CNT, 32'h0);
      bus(1'b1, `TMR_IDX_CTRL, 32'(cs));
      repeat (5) begin
        pin <= 1'b1;
        cyc(4);
        pin <= 1'b0;
        cyc(4);
      end
      cyc(8);
      bus(1'b1, `TMR_IDX_CTRL, 32'h0);
      bus(1'b0, `TMR_IDX_CNT, 32'h0);
      chk_word(rd, 32'h0000_0005);
    end
    // Dual slope: period 510, high 2*C non-inverted, 2*(255-C) inverted
    bus(1'b1, `TMR_IDX_FLAG, 32'h0000_0003);
    bus(1'b1, `TMR_IDX_CMP, 32'h0000_0080);
    bus(1'b1, `TMR_IDX_CTRL, 32'h0000_0061);
    cyc(1200);
    chk_word(per, 32'd510);
    chk_word(hi, 32'd256);
    chk_bit(ovf, 1'b1);
    bus(1'b1, `TMR_IDX_CTRL, 32'h0000_0071);
    // Service clear held through a bottom so that set and clear collide
    ack <= 2'b01;
    cyc(1200);
    ack <= 2'b00;
    chk_word(hi, 32'd254);
    bus(1'b1, `TMR_IDX_CTRL, 32'h0000_0062);
    cyc(9000);
    chk_word(per, 32'd4080);
    // Extreme compare values give a steady level
    bus(1'b1, `TMR_IDX_CTRL, 32'h0000_0061);
    bus(1'b1, `TMR_IDX_CMP, 32'h0000_0000);
    cyc(1100);
    r0 = rises;
    cyc(600);
    chk_word(rises, r0);
    chk_bit(lvl, 1'b0);
    bus(1'b1, `TMR_IDX_CMP, 32'h0000_00FF);
    cyc(1100);
    r0 = rises;
    cyc(600);
    chk_word(rises, r0);
    chk_bit(lvl, 1'b1);
    // Leaving the maximum compare value restores the symmetric period
    bus(1'b1, `TMR_IDX_CMP, 32'h0000_0080);
    // First low span starts at zero, not at the up match: 382 cycles, not 254
    do cyc(1); while (lvl !== 1'b0);
    r0 = 32'h0000_0000;
    do begin
      cyc(1);
      r0 = r0 + 32'h0000_0001;
    end while (lvl !== 1'b1);
    chk_word(r0, 32'd382);
    cyc(1200);
    chk_word(hi, 32'd256);
    bus(1'b1, `TMR_IDX_CTRL, 32'h0000_0069);
    cyc(700);
    chk_word(per, 32'd256);
    // Reset in mid-run returns everything to rest
    hresetn <= 1'b0;
    cyc(2);
    chk_bit(co, 1'b0);
    hresetn <= 1'b1;
    bus(1'b0, `TMR_IDX_CTRL, 32'h0);
    chk_word(rd, 32'h0000_0000);
    results();
  end
endmodule : timer8_waveform_mode_control_bench
